/* File: core/pcs_scale.sv */
// Purpose: Scale one converter word to 0.1 % units for the selected range
// Assumes: Converter word is synchronous; bipolar words are two's complement
// Notes:   Result held in a register, refreshed on each enable
`timescale 1ns/10ps
module pcs_scale (
	// Clock, reset and enable
	input logic clk_i,
	input logic rst_i,
	input logic en_i,
	// Conversion
	input pcs_pkg::pcs_range_t range_i,
	input logic [11:0] raw_i,
	output logic signed [15:0] pct_o
);
	logic signed [13:0] x;
	logic signed [12:0] gain;
	logic signed [26:0] prod;
	logic signed [26:0] y;
	logic bipolar;

	always_comb begin
		bipolar = (range_i == pcs_pkg::RNG_BI10V) || (range_i == pcs_pkg::RNG_BI5V);
		x = bipolar ? {{2{raw_i[11]}}, raw_i} : {2'b00, raw_i};
		if (range_i == pcs_pkg::RNG_4_20MA) begin
			x = x - {2'b00, pcs_pkg::LIVE_ZERO_CODE};
		end
		case (range_i)
			pcs_pkg::RNG_5V, pcs_pkg::RNG_BI5V: gain = pcs_pkg::GAIN_HALF;
			pcs_pkg::RNG_4_20MA: gain = pcs_pkg::GAIN_LIVE;
			default: gain = pcs_pkg::GAIN_FULL;
		endcase
		// Widen before multiplying: a 14-bit product would wrap
		prod = 27'(x) * 27'(gain);
		// Bipolar words span half the code range per polarity
		y = bipolar ? (prod >>> 11) : (prod >>> 12);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pct_o <= '0;
		end else if (en_i) begin
			if (y > 27'(pcs_pkg::PCT_POS)) begin
				pct_o <= pcs_pkg::PCT_POS;
			end else if (bipolar && y < 27'(pcs_pkg::PCT_NEG)) begin
				pct_o <= pcs_pkg::PCT_NEG;
			end else if (!bipolar && y < 0) begin
				pct_o <= '0;
			end else begin
				pct_o <= y[15:0];
			end
		end
	end
endmodule // pcs_scale

/* File: core/pcs_supervisor.sv */
// Purpose: PID_ACTIVE_FLAG control supervisor: source select, flags, switchover, sleep
// Assumes: Parameter and converter inputs are synchronous to clk_i
// Notes:   Percent values in 0.1 %, frequencies in 0.1 Hz, time in s
// Operation
// R1: PID_ACTIVE_FLAG only while selection terminal is on
// R2: Fieldbus command runs PID_ACTIVE_FLAG without terminal
// R3: Modes 20/21: setpoint terminal 2, measurement terminal 4
// R4: Modes 10/11: deviation taken from terminal 1
// R5: Invert terminal swaps forward and reverse action; code applies it in modes 10/11 and 20/21 only, not in 50/51/60/61
// R6: Terminal 2 range scaled to 0..100 %
// R7: Setpoint parameter used unless it is 9999
// R8: Terminal 1 bipolar, scaled to +-100 %
// R9: Terminal 4 range chosen by measurement select
// R10: Modes 50/51 and 60/61 use fieldbus values
// R11: Upper limit flag when measurement exceeds level
// R12: Lower limit flag when measurement below level
// R13: Direction flag high only for forward rotation
// R14: PID_ACTIVE_FLAG active flag while PID_ACTIVE_FLAG in effect
// R15: Suspend flag while suspended, unless disabled
// R16: Output code 100 or more inverts terminal
// R17: Normal start until auto switch frequency reached
// R18: Stay in PID_ACTIVE_FLAG after automatic switchover
// R19: Suspend when frequency low longer than time
// R20: Wake when deviation reaches cancel threshold
// R21: Suspended: suspend on, running off, PID_ACTIVE_FLAG on
// R22: Detect time 0..3600 s, 9999 disables
// R23: Detect level accepted 0..400 Hz
// R24: Cancel level 900..1100 %, 1000 is zero
// R25: Timer restarts when frequency reaches level
// R26: Flags updated once per control cycle
`timescale 1ns/10ps
module pcs_supervisor #(
	parameter int CTRL_CYCLE_CLKS = pcs_pkg::CTRL_CYCLE_CLKS
) (
	// Clock and reset
	input logic clk_i,
	input logic rst_i,
	// Input terminals, asynchronous pins
	input logic [11:0] in_term_i,
	input logic [95:0] in_assign_i,
	// Fieldbus
	input logic bus_pid_cmd_i,
	input logic signed [15:0] bus_sv_i,
	input logic signed [15:0] bus_pv_i,
	input logic signed [15:0] bus_dev_i,
	// Converter words
	input logic [11:0] adc_t1_i,
	input logic [11:0] adc_t2_i,
	input logic [11:0] adc_t4_i,
	// Parameters
	input logic [6:0] pid_action_select_i,
	input logic [15:0] setpoint_param_i,
	input logic [15:0] upper_limit_level_i,
	input logic [15:0] lower_limit_level_i,
	input logic [15:0] auto_switch_freq_i,
	input logic [15:0] suspend_detect_time_i,
	input logic [15:0] suspend_detect_level_i,
	input logic [15:0] suspend_cancel_level_i,
	input logic [4:0] analog_input_select_i,
	input logic [1:0] meas_input_range_select_i,
	input logic [55:0] out_assign_i,
	// Drive status
	input logic run_i,
	input logic rotation_fwd_i,
	input logic [15:0] out_freq_i,
	// Outputs
	output logic [6:0] out_term_o,
	output logic pid_mode_o,
	output logic reverse_action_o,
	output logic output_stop_o,
	output logic running_o,
	output logic signed [15:0] set_value_o,
	output logic signed [15:0] meas_value_o,
	output logic signed [15:0] deviation_o
);
	// ****************************************
	// Control cycle divider
	// ****************************************
	localparam logic [14:0] CYC_LAST = 15'(CTRL_CYCLE_CLKS - 1);
	logic [14:0] tick_cnt_reg;
	logic tick;

	assign tick = (tick_cnt_reg == CYC_LAST);

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 15'h1;
		end
	end

	// ****************************************
	// Terminal synchronisers and function decode
	// ****************************************
	logic [11:0] term_s1_reg;
	logic [11:0] term_s2_reg;
	logic [11:0] sel_hit;
	logic [11:0] inv_hit;
	logic pid_select;
	logic action_invert;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_s1_reg <= '0;
			term_s2_reg <= '0;
		end else begin
			term_s1_reg <= in_term_i;
			term_s2_reg <= term_s1_reg;
		end
	end

	for (genvar i = 0; i < pcs_pkg::N_IN; i++) begin : g_in
		assign sel_hit[i] = term_s2_reg[i] && (in_assign_i[8*i +: 8] == pcs_pkg::IN_FN_PID_SEL); // R1
		assign inv_hit[i] = term_s2_reg[i] && (in_assign_i[8*i +: 8] == pcs_pkg::IN_FN_INVERT); // R5
	end

	assign pid_select = |sel_hit;
	assign action_invert = |inv_hit;

	// ****************************************
	// Mode decode
	// ****************************************
	logic mode_dev_t;
	logic mode_meas_t;
	logic mode_dev_b;
	logic mode_meas_b;
	logic mode_valid;
	logic limit_mode;
	logic pid_req;

	assign mode_dev_t = (pid_action_select_i == pcs_pkg::MODE_DEV_T_REV)
		|| (pid_action_select_i == pcs_pkg::MODE_DEV_T_FWD);
	assign mode_meas_t = (pid_action_select_i == pcs_pkg::MODE_MEAS_T_REV)
		|| (pid_action_select_i == pcs_pkg::MODE_MEAS_T_FWD);
	assign mode_dev_b = (pid_action_select_i == pcs_pkg::MODE_DEV_B_REV)
		|| (pid_action_select_i == pcs_pkg::MODE_DEV_B_FWD);
	assign mode_meas_b = (pid_action_select_i == pcs_pkg::MODE_MEAS_B_REV)
		|| (pid_action_select_i == pcs_pkg::MODE_MEAS_B_FWD);
	assign mode_valid = mode_dev_t || mode_meas_t || mode_dev_b || mode_meas_b;
	assign limit_mode = mode_meas_t || mode_meas_b;
	// Fieldbus command stands in for the selection terminal
	assign pid_req = mode_valid && (pid_select || bus_pid_cmd_i); // R1 R2

	// ****************************************
	// Analog scaling
	// ****************************************
	logic [2:0][11:0] raw_arr;
	pcs_pkg::pcs_range_t rng_arr [3];
	logic signed [15:0] pct_arr [3];

	assign raw_arr = {adc_t4_i, adc_t2_i, adc_t1_i};

	always_comb begin
		case (analog_input_select_i)
			5'h02, 5'h03, 5'h05, 5'h07, 5'h0c, 5'h0d, 5'h0f, 5'h11: rng_arr[0] = pcs_pkg::RNG_BI5V; // R8
			default: rng_arr[0] = pcs_pkg::RNG_BI10V; // R8
		endcase
		case (analog_input_select_i)
			5'h01, 5'h03, 5'h05, 5'h0b, 5'h0d, 5'h0f: rng_arr[1] = pcs_pkg::RNG_5V; // R6
			5'h06, 5'h07: rng_arr[1] = pcs_pkg::RNG_4_20MA; // R6
			default: rng_arr[1] = pcs_pkg::RNG_10V; // R6
		endcase
		case (meas_input_range_select_i)
			2'h1: rng_arr[2] = pcs_pkg::RNG_5V; // R9
			2'h2: rng_arr[2] = pcs_pkg::RNG_10V; // R9
			default: rng_arr[2] = pcs_pkg::RNG_4_20MA; // R9
		endcase
	end

	for (genvar i = 0; i < 3; i++) begin : g_scale
		pcs_scale u_scale (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.en_i(tick),
			.range_i(rng_arr[i]),
			.raw_i(raw_arr[i]),
			.pct_o(pct_arr[i])
		);
	end

	// ****************************************
	// Set value, measured value and deviation
	// ****************************************
	logic signed [15:0] sv_c;
	logic signed [15:0] pv_c;
	logic signed [15:0] dev_c;
	logic [15:0] sp_clip;

	assign sp_clip = (setpoint_param_i > pcs_pkg::PCT_FULL) ? pcs_pkg::PCT_FULL : setpoint_param_i;

	always_comb begin
		sv_c = '0;
		pv_c = '0;
		dev_c = '0;
		if (mode_dev_t) begin
			dev_c = pct_arr[0]; // R4
		end else if (mode_dev_b) begin
			dev_c = bus_dev_i; // R10
		end else if (mode_meas_t) begin
			sv_c = (setpoint_param_i == pcs_pkg::NO_FUNC) ? pct_arr[1] : signed'(sp_clip); // R3 R7
			pv_c = pct_arr[2]; // R3
			dev_c = sv_c - pv_c;
		end else if (mode_meas_b) begin
			sv_c = bus_sv_i; // R10
			pv_c = bus_pv_i; // R10
			dev_c = sv_c - pv_c;
		end
	end

	// ****************************************
	// Parameter range handling
	// ****************************************
	logic [15:0] time_c;
	logic [15:0] level_c;
	logic [15:0] cancel_c;
	logic signed [15:0] wake_thr;
	logic sleep_en;
	logic auto_en;
	logic below;
	logic wake;

	// Out-of-range suspend settings are clipped; an auto switch frequency above FREQ_MAX disables start-up
	assign sleep_en = (suspend_detect_time_i != pcs_pkg::NO_FUNC); // R22
	assign time_c = (suspend_detect_time_i > pcs_pkg::TIME_MAX) ? pcs_pkg::TIME_MAX : suspend_detect_time_i; // R22
	assign level_c = (suspend_detect_level_i > pcs_pkg::FREQ_MAX) ? pcs_pkg::FREQ_MAX : suspend_detect_level_i; // R23
	assign cancel_c = (suspend_cancel_level_i < pcs_pkg::CANCEL_MIN) ? pcs_pkg::CANCEL_MIN
		: (suspend_cancel_level_i > pcs_pkg::CANCEL_MAX) ? pcs_pkg::CANCEL_MAX : suspend_cancel_level_i; // R24
	assign wake_thr = (signed'(cancel_c) - signed'(pcs_pkg::CANCEL_ZERO)) * pcs_pkg::CANCEL_STEP; // R24
	assign auto_en = (auto_switch_freq_i <= pcs_pkg::FREQ_MAX); // R17
	assign below = (out_freq_i < level_c);
	assign wake = (wake_thr >= 0) ? (dev_c >= wake_thr) : (dev_c <= wake_thr); // R20

	// ****************************************
	// Suspension timer
	// ****************************************
	logic [21:0] susp_cnt_reg;
	logic [21:0] susp_limit;
	logic sleep_go;

	assign susp_limit = 22'(time_c * pcs_pkg::TICKS_PER_SEC);
	assign sleep_go = below && (susp_cnt_reg >= susp_limit); // R19
	pcs_pkg::pcs_state_t state_reg;
	pcs_pkg::pcs_state_t state_next;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			susp_cnt_reg <= '0;
		end else if (tick) begin
			if (state_reg != pcs_pkg::ST_PID || !below) begin
				susp_cnt_reg <= '0; // R25
			end else if (susp_cnt_reg < susp_limit) begin
				susp_cnt_reg <= susp_cnt_reg + 22'h1; // R19
			end
		end
	end

	// ****************************************
	// Supervisor state machine
	// ****************************************
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pcs_pkg::ST_OFF: begin
				if (pid_req) begin
					state_next = (auto_en && out_freq_i < auto_switch_freq_i) ? pcs_pkg::ST_STARTUP
						: pcs_pkg::ST_PID; // R17
				end
			end
			pcs_pkg::ST_STARTUP: begin
				if (!pid_req) begin
					state_next = pcs_pkg::ST_OFF;
				end else if (out_freq_i >= auto_switch_freq_i) begin
					state_next = pcs_pkg::ST_PID; // R17
				end
			end
			pcs_pkg::ST_PID: begin
				// No path back to start-up once PID_ACTIVE_FLAG has taken over
				if (!pid_req) begin
					state_next = pcs_pkg::ST_OFF; // R18
				end else if (sleep_en && sleep_go) begin
					state_next = pcs_pkg::ST_SLEEP; // R19
				end
			end
			pcs_pkg::ST_SLEEP: begin
				if (!pid_req) begin
					state_next = pcs_pkg::ST_OFF;
				end else if (!sleep_en || wake) begin
					state_next = pcs_pkg::ST_PID; // R20
				end
			end
			default: state_next = pcs_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= pcs_pkg::ST_OFF;
		end else if (tick) begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Status flags, once per control cycle
	// ****************************************
	logic upper_reg;
	logic lower_reg;
	logic dir_reg;
	logic pid_reg;
	logic susp_reg;
	logic rev_reg;
	logic signed [15:0] set_value_reg;
	logic signed [15:0] meas_value_reg;
	logic signed [15:0] deviation_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upper_reg <= 1'b0;
			lower_reg <= 1'b0;
			dir_reg <= 1'b0;
			pid_reg <= 1'b0;
			susp_reg <= 1'b0;
			rev_reg <= 1'b0;
			set_value_reg <= '0;
			meas_value_reg <= '0;
			deviation_reg <= '0;
		end else if (tick) begin // R26
			upper_reg <= limit_mode && (upper_limit_level_i != pcs_pkg::NO_FUNC)
				&& (pv_c > signed'(upper_limit_level_i)); // R11
			lower_reg <= limit_mode && (lower_limit_level_i != pcs_pkg::NO_FUNC)
				&& (pv_c < signed'(lower_limit_level_i)); // R12
			dir_reg <= run_i && rotation_fwd_i; // R13
			pid_reg <= (state_next == pcs_pkg::ST_PID) || (state_next == pcs_pkg::ST_SLEEP); // R14 R21
			susp_reg <= sleep_en && (state_next == pcs_pkg::ST_SLEEP); // R15 R21
			rev_reg <= !pid_action_select_i[0] ^ (action_invert && (mode_dev_t || mode_meas_t)); // R5
			set_value_reg <= sv_c;
			meas_value_reg <= pv_c;
			deviation_reg <= dev_c;
		end
	end

	// ****************************************
	// Output terminals and drive status
	// ****************************************
	logic [6:0] term_val;
	logic [6:0] out_term_reg;
	logic stop_reg;
	logic running_reg;

	for (genvar i = 0; i < pcs_pkg::N_OUT; i++) begin : g_out
		logic [7:0] code;
		logic neg;
		logic [7:0] base;
		assign code = out_assign_i[8*i +: 8];
		assign neg = (code >= pcs_pkg::OUT_NEG_BASE); // R16
		assign base = neg ? (code - pcs_pkg::OUT_NEG_BASE) : code;
		always_comb begin
			case (base)
				pcs_pkg::OUT_FN_LOWER: term_val[i] = lower_reg ^ neg; // R16
				pcs_pkg::OUT_FN_UPPER: term_val[i] = upper_reg ^ neg; // R16
				pcs_pkg::OUT_FN_DIR: term_val[i] = dir_reg ^ neg; // R16
				pcs_pkg::OUT_FN_PID: term_val[i] = pid_reg ^ neg; // R16
				pcs_pkg::OUT_FN_SUSP: term_val[i] = susp_reg ^ neg; // R16
				default: term_val[i] = 1'b0;
			endcase
		end
		neg_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
			(code == pcs_pkg::OUT_FN_UPPER + pcs_pkg::OUT_NEG_BASE)
			|=> out_term_o[i] == !$past(upper_reg)) else $error("Negative-logic terminal wrong"); // R16
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_term_reg <= '0;
			stop_reg <= 1'b0;
			running_reg <= 1'b0;
		end else begin
			out_term_reg <= term_val;
			stop_reg <= (state_reg == pcs_pkg::ST_SLEEP); // R19
			running_reg <= run_i && (state_reg != pcs_pkg::ST_SLEEP); // R21
		end
	end

	assign out_term_o = out_term_reg;
	assign pid_mode_o = pid_reg;
	assign reverse_action_o = rev_reg;
	assign output_stop_o = stop_reg;
	assign running_o = running_reg;
	assign set_value_o = set_value_reg;
	assign meas_value_o = meas_value_reg;
	assign deviation_o = deviation_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	pid_select_a: assert property (tick && state_reg == pcs_pkg::ST_OFF && !pid_select && !bus_pid_cmd_i
		|=> state_reg == pcs_pkg::ST_OFF && !pid_reg) else $error("PID_ACTIVE_FLAG entered without request"); // R1
	bus_cmd_a: assert property (tick && state_reg == pcs_pkg::ST_OFF && bus_pid_cmd_i && mode_valid && !auto_en
		|=> state_reg == pcs_pkg::ST_PID) else $error("Fieldbus PID_ACTIVE_FLAG command ignored"); // R2
	setpoint_a: assert property (tick && mode_meas_t && setpoint_param_i <= pcs_pkg::PCT_FULL
		|=> set_value_reg == signed'($past(setpoint_param_i))) else $error("Setpoint parameter not used"); // R7
	dev_source_a: assert property (tick && mode_dev_t
		|=> deviation_reg == $past(pct_arr[0])) else $error("Deviation not from terminal 1"); // R4
	upper_mode_a: assert property (tick && !limit_mode |=> !upper_reg) else $error("Upper flag outside mode"); // R11
	lower_off_a: assert property (tick && lower_limit_level_i == pcs_pkg::NO_FUNC
		|=> !lower_reg) else $error("Lower flag while disabled"); // R12
	dir_stop_a: assert property (tick && !run_i |=> !dir_reg) else $error("Direction high while stopped"); // R13
	startup_a: assert property (state_reg == pcs_pkg::ST_STARTUP |-> !pid_reg) else $error("PID_ACTIVE_FLAG flag in start-up"); // R17
	auto_hold_a: assert property (state_reg == pcs_pkg::ST_PID
		|=> state_reg != pcs_pkg::ST_STARTUP) else $error("Left PID_ACTIVE_FLAG for start-up"); // R18
	timer_rst_a: assert property (tick && state_reg == pcs_pkg::ST_PID && !below
		|=> susp_cnt_reg == 0) else $error("Timer not restarted"); // R25
	sleep_flags_a: assert property (tick && state_next == pcs_pkg::ST_SLEEP
		|=> pid_reg && susp_reg ##1 !running_o && output_stop_o) else $error("Suspend outputs wrong"); // R21
	wake_up_a: assert property (tick && state_reg == pcs_pkg::ST_SLEEP && pid_req && wake
		|=> state_reg == pcs_pkg::ST_PID) else $error("No wake on deviation"); // R20

	sleep_c: cover property (tick && state_reg == pcs_pkg::ST_PID && state_next == pcs_pkg::ST_SLEEP);
	switch_c: cover property (tick && state_reg == pcs_pkg::ST_STARTUP && state_next == pcs_pkg::ST_PID);
	wake_c: cover property (tick && state_reg == pcs_pkg::ST_SLEEP && state_next == pcs_pkg::ST_PID);
endmodule // pcs_supervisor

/* File: inc/pcs_pkg.sv */
// Purpose: Shared constants and types for the PID_ACTIVE_FLAG control supervisor
// Assumes: 20 MHz clock, 1 ms control cycle, 0.1 % and 0.1 Hz units
// Notes:   Parameter codes are unsigned, 9999 means "no function"
package pcs_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int CTRL_CYCLE_NS = 1000000;
	localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;
	localparam int TICKS_PER_SEC = 1000000000 / CTRL_CYCLE_NS;
	// ****************************************
	// Terminal function codes
	// ****************************************
	localparam int N_IN = 12;
	localparam int N_OUT = 7;
	localparam logic [7:0] IN_FN_PID_SEL = 8'h0e;
	localparam logic [7:0] IN_FN_INVERT = 8'h40;
	localparam logic [7:0] OUT_FN_LOWER = 8'h0e;
	localparam logic [7:0] OUT_FN_UPPER = 8'h0f;
	localparam logic [7:0] OUT_FN_DIR = 8'h10;
	localparam logic [7:0] OUT_FN_PID = 8'h2f;
	localparam logic [7:0] OUT_FN_SUSP = 8'h46;
	localparam logic [7:0] OUT_NEG_BASE = 8'h64;
	// ****************************************
	// Action select codes
	// ****************************************
	localparam logic [6:0] MODE_DEV_T_REV = 7'h0a;
	localparam logic [6:0] MODE_DEV_T_FWD = 7'h0b;
	localparam logic [6:0] MODE_MEAS_T_REV = 7'h14;
	localparam logic [6:0] MODE_MEAS_T_FWD = 7'h15;
	localparam logic [6:0] MODE_DEV_B_REV = 7'h32;
	localparam logic [6:0] MODE_DEV_B_FWD = 7'h33;
	localparam logic [6:0] MODE_MEAS_B_REV = 7'h3c;
	localparam logic [6:0] MODE_MEAS_B_FWD = 7'h3d;
	// ****************************************
	// Levels and limits
	// ****************************************
	localparam logic [15:0] NO_FUNC = 16'h270f;
	localparam logic [15:0] PCT_FULL = 16'h03e8;
	localparam logic [15:0] FREQ_MAX = 16'h0fa0;
	localparam logic [15:0] TIME_MAX = 16'h0e10;
	localparam logic [15:0] CANCEL_MIN = 16'h0384;
	localparam logic [15:0] CANCEL_MAX = 16'h044c;
	localparam logic [15:0] CANCEL_ZERO = 16'h03e8;
	localparam logic signed [15:0] CANCEL_STEP = 16'sh000a;
	// ****************************************
	// Analog scaling (12-bit converter)
	// ****************************************
	localparam logic [11:0] LIVE_ZERO_CODE = 12'h333;
	localparam logic signed [12:0] GAIN_FULL = 13'sh03e8;
	localparam logic signed [12:0] GAIN_HALF = 13'sh07d0;
	localparam logic signed [12:0] GAIN_LIVE = 13'sh04e2;
	localparam logic signed [15:0] PCT_POS = 16'sh03e8;
	localparam logic signed [15:0] PCT_NEG = -16'sh03e8;
	typedef enum {RNG_10V, RNG_5V, RNG_4_20MA, RNG_BI10V, RNG_BI5V} pcs_range_t;
	typedef enum {ST_OFF, ST_STARTUP, ST_PID, ST_SLEEP} pcs_state_t;
endpackage

/* File: testbench/pcs_term_model.sv */
// Purpose: External controller driving the function input terminals
// Assumes: Selection on terminal 3, invert on terminal 7
// Notes:   Unused terminals toggle each clock so stray decoding shows
`timescale 1ns/10ps
module pcs_term_model (
	// Clock
	input wire logic clk_i,
	// Commands
	input wire logic pid_sel_i,
	input wire logic invert_i,
	// Terminals
	output logic [11:0] in_term_o,
	output logic [95:0] in_assign_o
);
	logic toggle_reg = 1'b0;
	always_ff @(posedge clk_i) begin
		toggle_reg <= ~toggle_reg;
	end
	always_comb begin
		in_assign_o = '0;
		in_assign_o[31:24] = pcs_pkg::IN_FN_PID_SEL;
		in_assign_o[63:56] = pcs_pkg::IN_FN_INVERT;
		in_term_o = {12{toggle_reg}};
		in_term_o[3] = pid_sel_i;
		in_term_o[7] = invert_i;
	end
endmodule // pcs_term_model

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the PID_ACTIVE_FLAG supervisor
// Assumes: Control cycle shortened to 8 clocks
// Notes:   Fieldbus modes give values free of converter latency
`timescale 1ns/10ps
module tb_top;
	// ****************************************
	// Stimulus and design
	// ****************************************
	localparam int CYC = 8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic pid_sel = 1'b0, inv = 1'b0, bus_cmd = 1'b0, run = 1'b1, rot = 1'b1, iv, up, lo;
	logic [11:0] term, a1 = 12'h000, a2 = 12'h000, a4 = 12'h000;
	logic [95:0] in_asg;
	logic [6:0] mode = 7'h00, out_term;
	logic [6:0] modes [8] = '{7'h0a, 7'h0b, 7'h14, 7'h15, 7'h32, 7'h33, 7'h3c, 7'h3d};
	logic [15:0] sp = 16'h0000, ul = 16'h270f, ll = 16'h270f, asw = 16'h270f, st = 16'h270f;
	logic [15:0] sl = 16'h0000, cl = 16'h03e8, fr = 16'h012c, v;
	logic signed [15:0] sv = 16'h0000, pv = 16'h0000, dv = 16'h0000, sv_o, pv_o, dv_o;
	logic [4:0] ais = 5'h00;
	logic [1:0] mrs = 2'h0;
	logic pm, ra, os, rn;
	int mismatches = 0;
	int comparisons = 0;
	always #25 clk_i = ~clk_i;
	pcs_term_model ctrl (.clk_i(clk_i), .pid_sel_i(pid_sel), .invert_i(inv), .in_term_o(term), .in_assign_o(in_asg));
	pcs_supervisor #(.CTRL_CYCLE_CLKS(CYC)) dut (.clk_i(clk_i), .rst_i(rst_i), .in_term_i(term),
		.in_assign_i(in_asg), .bus_pid_cmd_i(bus_cmd), .bus_sv_i(sv), .bus_pv_i(pv), .bus_dev_i(dv),
		.adc_t1_i(a1), .adc_t2_i(a2), .adc_t4_i(a4), .pid_action_select_i(mode), .setpoint_param_i(sp),
		.upper_limit_level_i(ul), .lower_limit_level_i(ll), .auto_switch_freq_i(asw),
		.suspend_detect_time_i(st), .suspend_detect_level_i(sl), .suspend_cancel_level_i(cl),
		.analog_input_select_i(ais), .meas_input_range_select_i(mrs),
		.out_assign_i(56'h00_73_46_93_10_72_0f), .run_i(run), .rotation_fwd_i(rot), .out_freq_i(fr),
		.out_term_o(out_term), .pid_mode_o(pm), .reverse_action_o(ra), .output_stop_o(os),
		.running_o(rn), .set_value_o(sv_o), .meas_value_o(pv_o), .deviation_o(dv_o));
	// ****************************************
	// Helpers
	// ****************************************
	// Terminals: 0 upper, 1 lower negative, 2 direction, 3 pid negative, 4 suspend, 5 upper negative
	function automatic logic [6:0] exp_term(input logic u, input logic l, input logic d, input logic p);
		return {1'b0, ~u, 1'b0, ~p, d, ~l, u};
	endfunction
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Fixed waits: every effect lands within a known number of control cycles
	task automatic ticks(input int n);
		repeat (n * CYC + 3) @(posedge clk_i);
	endtask
	task automatic conclude;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		void'($urandom(32'h937e));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			iv = 1'($urandom);
			mode <= modes[i];
			pid_sel <= 1'b1;
			inv <= iv;
			sp <= 16'($urandom_range(0, 1000));
			a1 <= 12'($urandom);
			a2 <= 12'($urandom);
			a4 <= 12'($urandom);
			ais <= 5'($urandom);
			mrs <= 2'($urandom);
			ticks(3);
			chk("pid_mode", 16'h0001, 16'(pm));
			chk("reverse", 16'(!modes[i][0] ^ (iv && modes[i] < 7'h32)), 16'(ra));
			if (modes[i][6:1] == 6'h0a) chk("set_value", sp, sv_o);
		end
		pid_sel <= 1'b0;
		ticks(3);
		chk("pid_mode", 16'h0000, 16'(pm));
		bus_cmd <= 1'b1;
		mode <= 7'h32;
		ticks(3);
		chk("pid_mode", 16'h0001, 16'(pm));
		$display("Test modes done");
		mode <= 7'h3c;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i);
			v = 16'($urandom_range(0, 1000));
			pv <= v;
			dv <= 16'($urandom);
			ul <= (i == 0) ? 16'h270f : (i == 1) ? v : 16'($urandom_range(0, 1000));
			ll <= (i == 1) ? v : 16'($urandom_range(0, 1000));
			rot <= 1'($urandom);
			ticks(3);
			up = ul != 16'h270f && int'(pv) > int'(ul);
			lo = ll != 16'h270f && int'(pv) < int'(ll);
			chk("out_term", 16'(exp_term(up, lo, rot, 1'b1)), 16'(out_term));
			chk("meas_value", v, pv_o);
		end
		$display("Test flags done");
		ul <= 16'h270f;
		ll <= 16'h270f;
		st <= 16'h0000;
		sl <= 16'h0064;
		fr <= 16'h0032;
		sv <= 16'h01f4;
		pv <= 16'h0258;
		ticks(4);
		chk("stop", 16'h0001, 16'(os));
		chk("running", 16'h0000, 16'(rn));
		chk("pid_mode", 16'h0001, 16'(pm));
		chk("sleep_term", 16'h0001, 16'(out_term[4]));
		chk("meas_value", 16'h0258, pv_o);
		chk("deviation", 16'hff9c, dv_o);
		pv <= 16'h0190;
		fr <= 16'h012c;
		ticks(2);
		chk("stop", 16'h0000, 16'(os));
		chk("running", 16'h0001, 16'(rn));
		$display("Test sleep done");
		bus_cmd <= 1'b0;
		st <= 16'h270f;
		ticks(3);
		mode <= 7'h14;
		pid_sel <= 1'b1;
		asw <= 16'h01f4;
		fr <= 16'h0064;
		ticks(3);
		chk("pid_mode", 16'h0000, 16'(pm));
		fr <= 16'h0258;
		ticks(2);
		chk("pid_mode", 16'h0001, 16'(pm));
		fr <= 16'h0064;
		ticks(3);
		chk("pid_mode", 16'h0001, 16'(pm));
		$display("Test switchover done");
		conclude();
	end
endmodule // tb_top
